// ---- common/rxfpb_pkg.sv ----
package rxfpb_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses, one register every four bytes)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_BUF_CFG   = 8'h00;
  localparam logic [7:0] ADDR_RX_CFG    = 8'h04;
  localparam logic [7:0] ADDR_BUS_CTL   = 8'h08;
  localparam logic [7:0] ADDR_ACC_CTL   = 8'h0c;
  localparam logic [7:0] ADDR_RX_EVENT  = 8'h10;
  localparam logic [7:0] ADDR_BUF_EVENT = 8'h14;
  localparam logic [7:0] ADDR_EVQ       = 8'h18;
  localparam logic [7:0] ADDR_STATUS    = 8'h1c;
  localparam logic [7:0] ADDR_LENGTH    = 8'h20;
  localparam logic [7:0] ADDR_DATA      = 8'h24;
  localparam logic [7:0] ADDR_MISS      = 8'h28;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_DMA_DONE_IE   = 7;
  localparam int BIT_MISSED_IE     = 10;
  localparam int BIT_EARLY_IE      = 11;
  localparam int BIT_MISS_WRAP_IE  = 13;
  localparam int BIT_DEST_IE       = 15;
  localparam int BIT_SKIP          = 6;
  localparam int BIT_STREAM        = 7;
  localparam int BIT_DMA_ONLY      = 9;
  localparam int BIT_AUTO_SWITCH   = 10;
  localparam int BIT_KEEP_FCS      = 11;
  localparam int BIT_HOLD_LIMIT    = 11;
  localparam int BIT_WINDOW_SIZE   = 13;
  localparam int BIT_RX_OK_IE      = 8;
  localparam int BIT_RX_OK         = 8;
  localparam int BIT_PROMISC       = 7;
  localparam int BIT_CRC_ERR_A     = 12;
  localparam int BIT_CRC_ERR       = 12;
  localparam int BIT_EV_DMA_DONE   = 7;
  localparam int BIT_EV_MISSED     = 10;
  localparam int BIT_EV_EARLY      = 11;
  localparam int BIT_EV_MISS_WRAP  = 13;
  localparam int BIT_EV_DEST       = 15;

  localparam logic [15:0] BUF_CFG_MASK  = 16'hac80;
  localparam logic [15:0] RX_CFG_MASK   = 16'h1e80;
  localparam logic [15:0] BUS_CTL_MASK  = 16'h2800;
  localparam logic [15:0] ACC_CTL_MASK  = 16'h7fc0;
  localparam logic [15:0] RESET_ZERO    = 16'h0000;

  localparam logic [10:0] EARLY_BYTES   = 11'd128;
  localparam logic [10:0] DEST_BYTES    = 11'd6;
  localparam logic [10:0] MAX_BYTES     = 11'd1518;
  localparam logic [10:0] FCS_BYTES     = 11'd4;

  // Bus hold limit for DMA
  localparam int CLK_HZ      = 25_000_000;
  localparam int HOLD_US     = 28;
  localparam int HOLD_CYCLES = HOLD_US * (CLK_HZ / 1_000_000);

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    RXFPB_IDLE = 2'b00,
    RXFPB_RECV = 2'b01,
    RXFPB_HELD = 2'b11,
    RXFPB_DROP = 2'b10
  } rxfpb_state_type;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
    logic       destPass;
    logic       crcBad;
  } rxfpb_mac_type;

endpackage

// ---- core/rxfpb_core.sv ----
// Local design decisions: the address map and register access over Wishbone.
module rxfpb_core #(
  parameter int DEPTH       = 1536,
  parameter int HOLD_CYCLES = rxfpb_pkg::HOLD_CYCLES
) (
  // System
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        wb_err_o,
  // MAC receive byte stream
  input  wire rxfpb_pkg::rxfpb_mac_type macRx,
  // DMA engine events and controls
  input  wire logic                   dmaFrameDone,
  input  wire logic                   dmaBusGrant,
  output logic                        dmaBusRelease,
  output logic                        dmaWindowLarge,
  output logic                        dmaRoute,
  output logic                        streamingXferEn,
  // Interrupt request
  output logic                        irq
);
  import rxfpb_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  logic [15:0]     bufferIrqConfigReg;
  logic [15:0]     receiveConfigReg;
  logic [15:0]     hostBusControlReg;
  logic [15:0]     acceptanceControlReg;
  logic [15:0]     receiveEventReg;
  logic [15:0]     bufferEventReg;
  logic [15:0]     frameStatusReg;
  logic [10:0]     frameLengthReg;
  logic [15:0]     missedFrameCounter;
  logic [7:0]      frameMem [DEPTH];
  logic [10:0]     byteCount;
  logic [10:0]     readPtr;
  logic            committed;
  logic            complete;
  logic            readPhase;
  rxfpb_state_type state;
  logic [31:0]     holdCount;
  logic [15:0]     readData;
  logic            access;
  logic            readRxEv;
  logic            readBufEv;
  logic            readEvq;
  logic            readData16;
  logic            mapped;
  logic            frameEnd;
  logic            accept;
  logic            skipReq;
  logic            implied;
  logic            release_;
  logic            missEvt;
  logic            storeByte;
  logic            inFrame;
  logic            frameStart;

  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mapped = wb_adr_i <= ADDR_MISS && wb_adr_i[1:0] == 2'b00;
  assign readRxEv  = access && !wb_we_i && wb_adr_i == ADDR_RX_EVENT;
  assign readBufEv = access && !wb_we_i && wb_adr_i == ADDR_BUF_EVENT;
  // Queue reads report the buffer event first when it holds anything
  assign readEvq = access && !wb_we_i && wb_adr_i == ADDR_EVQ;
  assign readData16 = access && !wb_we_i && wb_adr_i == ADDR_DATA;
  assign skipReq = access && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == ADDR_RX_CFG && wb_dat_i[BIT_SKIP];

  function automatic logic wr(input logic [7:0] a);
    wr = access && wb_we_i && wb_adr_i == a && wb_sel_i[1:0] == 2'b11;
  endfunction

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bufferIrqConfigReg   <= RESET_ZERO;
      receiveConfigReg     <= RESET_ZERO;
      hostBusControlReg    <= RESET_ZERO;
      acceptanceControlReg <= RESET_ZERO;
    end
    else
    begin
      if (wr(ADDR_BUF_CFG))
        bufferIrqConfigReg <= wb_dat_i[15:0] & BUF_CFG_MASK;
      if (wr(ADDR_RX_CFG))
        receiveConfigReg <= wb_dat_i[15:0] & RX_CFG_MASK;
      if (wr(ADDR_BUS_CTL))
        hostBusControlReg <= wb_dat_i[15:0] & BUS_CTL_MASK;
      if (wr(ADDR_ACC_CTL))
        acceptanceControlReg <= wb_dat_i[15:0] & ACC_CTL_MASK;
    end
  end

  // Transfer method outputs
  assign streamingXferEn = receiveConfigReg[BIT_STREAM];
  assign dmaWindowLarge  = hostBusControlReg[BIT_WINDOW_SIZE];

  // ------------------------------------------------------------
  // Receive pre-processing
  // ------------------------------------------------------------
  assign frameEnd = macRx.valid && macRx.last;
  // Promiscuous, good frames, or bad-CRC frames when allowed
  assign accept = acceptanceControlReg[BIT_PROMISC]
                  || (!macRx.crcBad && acceptanceControlReg[BIT_RX_OK])
                  || (macRx.crcBad && acceptanceControlReg[BIT_CRC_ERR_A]);
  // Last four bytes are FCS; dropped from the count unless kept
  assign storeByte = macRx.valid && byteCount < MAX_BYTES;
  assign implied = readRxEv && complete && readPtr != RESET_ZERO[10:0]
                   && readPtr < frameLengthReg;
  assign release_ = skipReq || implied
                    || (readData16 && readPhase && readPtr + 11'd2 >= frameLengthReg);
  assign frameStart = macRx.valid && !inFrame;
  assign missEvt = frameStart && macRx.destPass && (committed || complete);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      inFrame <= 1'b0;
    else if (macRx.valid)
      inFrame <= !macRx.last;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state          <= RXFPB_IDLE;
      byteCount      <= 11'd0;
      complete       <= 1'b0;
      frameLengthReg <= 11'd0;
      frameStatusReg <= RESET_ZERO;
      dmaRoute       <= 1'b0;
    end
    else
    begin
      unique case (state)
        RXFPB_IDLE:
        begin
          if (frameStart && !committed && !complete)
          begin
            if (macRx.destPass)
            begin
              state     <= frameEnd ? RXFPB_IDLE : RXFPB_RECV;
              byteCount <= 11'd1;
              dmaRoute  <= receiveConfigReg[BIT_DMA_ONLY];
            end
            else if (!frameEnd)
              state <= RXFPB_DROP;
          end
          else if (missEvt && !frameEnd)
            state <= RXFPB_DROP;
        end
        RXFPB_RECV:
        begin
          if (storeByte)
            byteCount <= byteCount + 11'd1;
          if (frameEnd)
          begin
            if (accept)
            begin
              state    <= RXFPB_HELD;
              complete <= 1'b1;
              frameLengthReg <= receiveConfigReg[BIT_KEEP_FCS] ?
                                byteCount + 11'd1 : byteCount + 11'd1 - FCS_BYTES;
              frameStatusReg <= {3'b000, macRx.crcBad, 3'b000,
                                 !macRx.crcBad, 8'h00};
            end
            else
              state <= RXFPB_IDLE;
          end
        end
        RXFPB_HELD:
        begin
          if (release_)
          begin
            state    <= RXFPB_IDLE;
            complete <= 1'b0;
          end
        end
        RXFPB_DROP:
        begin
          if (frameEnd)
            state <= RXFPB_IDLE;
        end
      endcase
    end
  end

  // Frame memory write
  always_ff @(posedge clk)
  begin
    if (state == RXFPB_RECV && storeByte)
      frameMem[byteCount[AW-1:0]] <= macRx.data;
    else if (state == RXFPB_IDLE && frameStart && macRx.destPass && !committed && !complete)
      frameMem[0] <= macRx.data;
  end

  // ------------------------------------------------------------
  // Commitment and host read-out
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      committed <= 1'b0;
      readPtr   <= 11'd0;
      readPhase <= 1'b0;
    end
    else
    begin
      if (release_)
      begin
        committed <= 1'b0;
        readPtr   <= 11'd0;
        readPhase <= 1'b0;
      end
      else
      begin
        if ((complete && (readRxEv || readEvq))
            || ((bufferEventReg[BIT_EV_DEST] || bufferEventReg[BIT_EV_EARLY])
                && (readBufEv || readEvq)))
          committed <= 1'b1;
        // Data port returns status, length, then frame data
        if (readData16 && (committed || complete))
        begin
          if (!readPhase && readPtr == 11'd2)
          begin
            readPhase <= 1'b1;
            readPtr   <= 11'd0;
          end
          else if (!readPhase)
            readPtr <= readPtr + 11'd2;
          else if (readPtr < byteCount)
            readPtr <= readPtr + 11'd2;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Event registers
  // ------------------------------------------------------------
  logic evqBuf;
  assign evqBuf = bufferEventReg != RESET_ZERO;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bufferEventReg     <= RESET_ZERO;
      receiveEventReg    <= RESET_ZERO;
      missedFrameCounter <= RESET_ZERO;
    end
    else
    begin
      // Host read clears, set from the same cycle wins
      if (readBufEv || (readEvq && evqBuf))
        bufferEventReg <= RESET_ZERO;
      if (readRxEv || (readEvq && !evqBuf))
        receiveEventReg <= RESET_ZERO;
      if (state == RXFPB_RECV && byteCount == DEST_BYTES - 11'd1 && macRx.valid)
        bufferEventReg[BIT_EV_DEST] <= 1'b1;
      if (state == RXFPB_RECV && byteCount == EARLY_BYTES - 11'd1 && macRx.valid)
      begin
        bufferEventReg[BIT_EV_EARLY] <= 1'b1;
        bufferEventReg[BIT_EV_DEST]  <= 1'b0;
      end
      if (state == RXFPB_RECV && frameEnd)
      begin
        bufferEventReg[BIT_EV_EARLY] <= 1'b0;
        if (accept)
          receiveEventReg <= {3'b000, macRx.crcBad, 3'b000, !macRx.crcBad, 8'h04};
      end
      if (dmaFrameDone)
        bufferEventReg[BIT_EV_DMA_DONE] <= 1'b1;
      if (missEvt)
      begin
        bufferEventReg[BIT_EV_MISSED] <= 1'b1;
        missedFrameCounter <= missedFrameCounter + 16'h0001;
        if (missedFrameCounter == 16'hffff)
          bufferEventReg[BIT_EV_MISS_WRAP] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt and DMA bus tenure
  // ------------------------------------------------------------
  logic [15:0] irqMask;
  always_comb
  begin
    irqMask = bufferIrqConfigReg;
    if (committed)
    begin
      irqMask[BIT_EARLY_IE] = 1'b0;
      irqMask[BIT_DEST_IE]  = 1'b0;
    end
  end
  assign irq = |(bufferEventReg & irqMask);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      holdCount <= 32'd0;
    else if (dmaBusGrant)
      holdCount <= holdCount + 32'd1;
    else
      holdCount <= 32'd0;
  end
  assign dmaBusRelease = hostBusControlReg[BIT_HOLD_LIMIT]
                         && holdCount >= HOLD_CYCLES - 1;

  // ------------------------------------------------------------
  // Wishbone read mux and acknowledge
  // ------------------------------------------------------------
  always_comb
  begin
    readData = RESET_ZERO;
    unique case (wb_adr_i)
      ADDR_BUF_CFG:   readData = bufferIrqConfigReg;
      ADDR_RX_CFG:    readData = receiveConfigReg;
      ADDR_BUS_CTL:   readData = hostBusControlReg;
      ADDR_ACC_CTL:   readData = acceptanceControlReg;
      ADDR_RX_EVENT:  readData = receiveEventReg;
      ADDR_BUF_EVENT: readData = bufferEventReg;
      ADDR_EVQ:       readData = evqBuf ? bufferEventReg : receiveEventReg;
      ADDR_STATUS:    readData = frameStatusReg;
      ADDR_LENGTH:    readData = {5'd0, frameLengthReg};
      ADDR_DATA:
        if (!readPhase)
          readData = readPtr == 11'd0 ? frameStatusReg : {5'd0, frameLengthReg};
        else
          readData = {frameMem[readPtr[AW-1:0] + 1'b1], frameMem[readPtr[AW-1:0]]};
      ADDR_MISS:      readData = missedFrameCounter;
      default:        readData = RESET_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= access && mapped;
      wb_err_o <= access && !mapped;
      wb_dat_o <= {16'h0000, readData};
    end
  end

endmodule

// ---- verification/rxfpb_core_properties.sv ----
module rxfpb_core_properties (
  // System
  input wire logic        clk,
  input wire logic        reset_n,
  // Wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // DMA and interrupt
  input wire logic        dmaFrameDone,
  input wire logic        dmaBusRelease,
  input wire logic        dmaWindowLarge,
  input wire logic        streamingXferEn,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import rxfpb_pkg::*;

  logic [15:0] bufCfgShadow;
  logic [15:0] rxCfgShadow;
  logic [15:0] busCtlShadow;
  logic        wrDone;
  logic        holdOn;
  logic        irqCfgOff;

  assign wrDone = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && (wb_sel_i[1:0] == 2'b11);
  assign holdOn = busCtlShadow[BIT_HOLD_LIMIT];
  assign irqCfgOff = (bufCfgShadow == 16'h0000) && !rxCfgShadow[BIT_CRC_ERR];

  // Shadow of the buffer, receive and bus control configuration words, masked as the core stores them
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bufCfgShadow <= 16'h0000;
      rxCfgShadow  <= 16'h0000;
      busCtlShadow <= 16'h0000;
    end
    else if (wrDone)
    begin
      if (wb_adr_i == ADDR_BUF_CFG)
        bufCfgShadow <= wb_dat_i[15:0] & BUF_CFG_MASK;
      if (wb_adr_i == ADDR_RX_CFG)
        rxCfgShadow <= wb_dat_i[15:0] & RX_CFG_MASK;
      if (wb_adr_i == ADDR_BUS_CTL)
        busCtlShadow <= wb_dat_i[15:0] & BUS_CTL_MASK;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence takeReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence

  sequence cfgWrite(logic [7:0] adr);
    wrDone && (wb_adr_i == adr);
  endsequence

  chk_ack_one_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_answer_next:
    assert property (takeReq |=> (wb_ack_o || wb_err_o)) else $error("request not answered");
  chk_err_unmapped:
    assert property (takeReq ##0 (wb_adr_i > ADDR_MISS) |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  chk_read_high_zero:
    assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_window_follow:
    assert property (cfgWrite(ADDR_BUS_CTL) |=> dmaWindowLarge == busCtlShadow[BIT_WINDOW_SIZE])
    else $error("window size output wrong");
  chk_stream_follow:
    assert property (cfgWrite(ADDR_RX_CFG) |=> streamingXferEn == rxCfgShadow[BIT_STREAM])
    else $error("stream enable output wrong");
  chk_dma_done_irq:
    assert property (dmaFrameDone && bufCfgShadow[BIT_DMA_DONE_IE] |-> ##[1:3] irq)
    else $error("no interrupt after dma done");
  chk_no_hold_limit:
    assert property (!holdOn && !$past(holdOn) |-> !dmaBusRelease)
    else $error("bus released without hold limit");
  chk_irq_needs_en:
    assert property (irqCfgOff && $past(irqCfgOff) |-> !irq) else $error("irq with no enable");
endmodule

bind rxfpb_core rxfpb_core_properties rxfpb_core_properties_inst (
  .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .dmaFrameDone(dmaFrameDone), .dmaBusRelease(dmaBusRelease),
  .dmaWindowLarge(dmaWindowLarge), .streamingXferEn(streamingXferEn), .irq(irq)
);

// ---- verification/rxfpb_mac_source.sv ----
module rxfpb_mac_source (
  // System
  input  wire logic             clk,
  // Byte stream toward the block
  output rxfpb_pkg::rxfpb_mac_type macRx
);
  timeunit 1ns;
  timeprecision 1ps;
  import rxfpb_pkg::*;

  logic [7:0] lastByte;

  initial
  begin
    macRx = '0;
    lastByte = 8'h00;
  end

  // Bytes first..first+count-1, gap idle cycles after each; idle data toggles
  task automatic send(input int first, input int count, input logic isLast,
                      input logic pass, input int gap);
    for (int i = first; i < first + count; i++)
    begin
      @(posedge clk);
      lastByte = 8'(i) ^ 8'h5a;
      macRx.valid <= 1'b1;
      macRx.data <= lastByte;
      macRx.last <= isLast && (i == first + count - 1);
      macRx.destPass <= pass;
      macRx.crcBad <= 1'b0;
      repeat (gap)
      begin
        @(posedge clk);
        macRx.valid <= 1'b0;
        macRx.data <= ~lastByte;
      end
    end
    @(posedge clk);
    macRx.valid <= 1'b0;
    macRx.last <= 1'b0;
    macRx.data <= ~lastByte;
  endtask
endmodule

// ---- verification/tb_rx_frame_preprocess_buffer.sv ----
module tb_rx_frame_preprocess_buffer;
  timeunit 1ns;
  timeprecision 1ps;
  import rxfpb_pkg::*;

  localparam int SIM_HOLD = 8;

  logic          clk;
  logic          resetN;
  logic          wbCyc;
  logic          wbStb;
  logic          wbWe;
  logic [7:0]    wbAdr;
  logic [31:0]   wbDatI;
  logic [31:0]   wbDatO;
  logic          wbAck;
  logic          wbErr;
  rxfpb_mac_type macRx;
  logic          dmaFrameDone;
  logic          dmaBusGrant;
  logic          dmaBusRelease;
  logic          dmaWindowLarge;
  logic          streamingXferEn;
  logic          irq;
  int            miscompares;
  int            numChecks;

  rxfpb_core #(.HOLD_CYCLES(SIM_HOLD)) rxfpb_core_inst (
    .clk(clk), .reset_n(resetN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .wb_err_o(wbErr), .macRx(macRx), .dmaFrameDone(dmaFrameDone),
    .dmaBusGrant(dmaBusGrant), .dmaBusRelease(dmaBusRelease),
    .dmaWindowLarge(dmaWindowLarge), .dmaRoute(), .streamingXferEn(streamingXferEn),
    .irq(irq)
  );

  rxfpb_mac_source rxfpb_mac_source_inst (.clk(clk), .macRx(macRx));

  always #20 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic we, input logic [7:0] adr, input logic [15:0] dat,
                     output logic [15:0] rdat, output logic err);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= {16'h0000, dat};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      miscompares++;
      stop_test();
    end
    rdat = wbDatO[15:0];
    err = wbErr;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [15:0] dat);
    logic [15:0] d;
    logic        e;
    bus(1'b1, adr, dat, d, e);
  endtask

  task automatic rd(input logic [7:0] adr, output logic [15:0] dat);
    logic e;
    bus(1'b0, adr, 16'h0000, dat, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic frame(input int first, input int count, input logic isLast, input logic pass);
    rxfpb_mac_source_inst.send(first, count, isLast, pass, 0);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_regs();
    logic [7:0]  adrs [3] = '{ADDR_BUF_CFG, ADDR_RX_CFG, ADDR_BUS_CTL};
    logic [15:0] masks [3] = '{BUF_CFG_MASK, RX_CFG_MASK, BUS_CTL_MASK};
    logic [15:0] v;
    logic        e;
    for (int i = 0; i < 3; i++)
    begin
      rd(adrs[i], v);
      check(v, RESET_ZERO);
      wr(adrs[i], 16'hffff);
      rd(adrs[i], v);
      check(v, masks[i] & ~16'h0040);
    end
    check(16'(streamingXferEn), 16'h0001);
    check(16'(dmaWindowLarge), 16'h0001);
    bus(1'b0, 8'h2c, 16'h0000, v, e);
    check(16'(e), 16'h0001);
    for (int i = 0; i < 3; i++)
      wr(adrs[i], 16'h0000);
    $display("test_regs done");
  endtask

  task automatic test_frames();
    logic [15:0] v;
    wr(ADDR_ACC_CTL, 16'h0100);
    wr(ADDR_RX_CFG, 16'h0800);
    wr(ADDR_BUF_CFG, 16'h8800);
    frame(0, 20, 1'b1, 1'b0);
    idle(3);
    check(16'(irq), 16'h0000);
    rd(ADDR_BUF_EVENT, v);
    check(v, 16'h0000);
    frame(0, 6, 1'b0, 1'b1);
    idle(3);
    check(16'(irq), 16'h0001);
    frame(6, 122, 1'b0, 1'b1);
    idle(3);
    rd(ADDR_BUF_EVENT, v);
    check(v, 16'h0800);
    idle(2);
    check(16'(irq), 16'h0000);
    rxfpb_mac_source_inst.send(128, 36, 1'b1, 1'b1, 1);
    idle(3);
    rd(ADDR_BUF_EVENT, v);
    check(v, 16'h0000);
    rd(ADDR_RX_EVENT, v);
    check(16'(v[BIT_RX_OK]), 16'h0001);
    rd(ADDR_RX_EVENT, v);
    check(v, 16'h0000);
    rd(ADDR_LENGTH, v);
    check(v, 16'd164);
    rd(ADDR_DATA, v);
    rd(ADDR_DATA, v);
    check(v, 16'd164);
    rd(ADDR_DATA, v);
    check(v, 16'h5b5a);
    frame(0, 6, 1'b0, 1'b1);
    idle(3);
    check(16'(irq), 16'h0000);
    frame(6, 58, 1'b1, 1'b1);
    idle(3);
    rd(ADDR_LENGTH, v);
    check(v, 16'd164);
    rd(ADDR_BUF_EVENT, v);
    check(v, 16'h0400);
    wr(ADDR_RX_CFG, 16'h0840);
    frame(0, 64, 1'b1, 1'b1);
    idle(3);
    rd(ADDR_RX_EVENT, v);
    check(16'(v[BIT_RX_OK]), 16'h0001);
    rd(ADDR_LENGTH, v);
    check(v, 16'd64);
    rd(ADDR_BUF_EVENT, v);
    check(v, 16'h8000);
    wr(ADDR_RX_CFG, 16'h0040);
    wr(ADDR_BUF_CFG, 16'h0000);
    $display("test_frames done");
  endtask

  task automatic test_dma();
    logic [15:0] v;
    for (int en = 1; en >= 0; en--)
    begin
      wr(ADDR_BUF_CFG, en ? 16'h0080 : 16'h0000);
      @(posedge clk);
      dmaFrameDone <= 1'b1;
      @(posedge clk);
      dmaFrameDone <= 1'b0;
      idle(2);
      check(16'(irq), 16'(en));
      rd(en ? ADDR_BUF_EVENT : ADDR_EVQ, v);
      check(v, 16'h0080);
      idle(2);
      check(16'(irq), 16'h0000);
    end
    $display("test_dma done");
  endtask

  task automatic test_hold();
    int   n;
    logic seen;
    wr(ADDR_BUS_CTL, 16'h0800);
    @(posedge clk);
    dmaBusGrant <= 1'b1;
    n = 0;
    while (dmaBusRelease !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    check(16'(n <= SIM_HOLD + 3), 16'h0001);
    @(posedge clk);
    dmaBusGrant <= 1'b0;
    wr(ADDR_BUS_CTL, 16'h0000);
    @(posedge clk);
    dmaBusGrant <= 1'b1;
    seen = 1'b0;
    repeat (30)
    begin
      @(posedge clk);
      seen = seen | dmaBusRelease;
    end
    check(16'(seen), 16'h0000);
    dmaBusGrant <= 1'b0;
    $display("test_hold done");
  endtask

  initial
  begin
    clk = 1'b0;
    resetN = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbDatI = 32'h0000_0000;
    dmaFrameDone = 1'b0;
    dmaBusGrant = 1'b0;
    miscompares = 0;
    numChecks = 0;
    repeat (20) @(posedge clk);
    resetN <= 1'b1;
    test_regs();
    test_frames();
    test_dma();
    test_hold();
    stop_test();
  end
endmodule
